/* verilog/tcm_pkg.sv */
// Constants, types and state layout of the 16-bit capture/compare timer
package tcm_pkg;
    // ==========================================
    // Register byte addresses
    localparam int          AW     = 6;
    localparam logic [5:0]  A_CTLA = 6'h00;
    localparam logic [5:0]  A_CTLB = 6'h04;
    localparam logic [5:0]  A_MODA = 6'h08;
    localparam logic [5:0]  A_MODB = 6'h0c;
    localparam logic [5:0]  A_SDAT = 6'h10;
    localparam logic [5:0]  A_FLG  = 6'h14;
    localparam logic [5:0]  A_MSK  = 6'h18;
    localparam logic [5:0]  A_CMP  = 6'h1c;
    localparam logic [5:0]  A_CAP  = 6'h20;
    localparam logic [5:0]  A_CNT  = 6'h24;
    // ==========================================
    // Field positions
    localparam int CA_EN = 7, CA_TS = 6, CA_ICS = 5, CA_CRM = 3;
    localparam int CA_CR = 2, CA_CTM = 1, CA_OTM = 0, CB_SCE = 0;
    localparam int MA_TOP = 3, MA_EDG = 5, MA_FLT = 7;
    localparam int MB_SSI = 4, MB_POL = 5, MB_CPR = 6, MB_PRE = 7;
    localparam int F_CAP = 0, F_CMP = 1, F_OVF = 2;
    localparam int F_RX = 3, F_TX = 4, F_TC = 5;
    localparam logic [7:0] CTLA_RW = 8'hef;
    // ==========================================
    // Count limits, filter, bus answers
    localparam logic [15:0] MAXC = 16'hffff;
    localparam logic [15:0] TOP1 = 16'h00ff;
    localparam logic [15:0] TOP2 = 16'h01ff;
    localparam logic [15:0] TOP3 = 16'h03ff;
    localparam int          FLT_W = 3;
    localparam logic [2:0]  FLT_LEN = 3'h4;
    localparam logic [1:0]  R_OK = 2'b00;
    localparam logic [1:0]  R_SLV = 2'b10;
    // ==========================================
    // Types
    typedef enum logic [3:0] {
        MD_PORT = 4'h0, MD_TG1 = 4'h1, MD_TG2 = 4'h2, MD_TGB = 4'h3,
        MD_SSI = 4'h4, MD_MAN = 4'h5, MD_BIP = 4'h6, MD_PWM = 4'h7
    } tcm_mode_e;
    typedef enum logic [0:0] {SS_IDLE = 1'b0, SS_SHIFT = 1'b1} tcm_ss_e;
    typedef struct packed {
        logic t0, t1, t3, sens, base, ext_a, ext_b;
    } tcm_src_s;
    typedef struct packed {
        logic out1, out2, serin, dir1, dir2, dirs;
    } tcm_port_s;
    typedef struct packed {
        logic [7:0]  ctla, ctlb, moda, modb, txb, rxb, sr;
        logic [15:0] cmp, cap, cnt;
        logic [5:0]  flg, msk;
        logic [2:0]  bits;
        tcm_ss_e     ss;
        logic        txf, ph, so, bi, m2, stg, o1, o2;
        logic [1:0]  sya, syb, syc, sys;
        logic        srcd, capd, flt;
        logic [FLT_W-1:0] fcnt;
        logic        awv, wv, bv, rv;
        logic [5:0]  awa;
        logic [31:0] wd, rd;
        logic [3:0]  ws;
        logic [1:0]  br, rr;
    } tcm_st_s;
endpackage

/* verilog/tcm_timer.sv */
// 16-bit timer with capture, compare, modulator and serial stream unit
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module tcm_timer (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [5:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [5:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire tcm_pkg::tcm_src_s  clk_src,
    input  wire logic               capture_input_pin,
    input  wire tcm_pkg::tcm_port_s port_ctl,
    input  wire logic               serial_in_pin,
    output logic                    mod_out_pin_1,
    output logic                    mod_out_pin_1_oe,
    output logic                    mod_out_pin_2,
    output logic                    mod_out_pin_2_oe,
    output logic                    port_pin_serin,
    output logic                    port_pin_serin_oe,
    output logic                    stage_output_clock,
    output logic                    capture_irq,
    output logic                    compare_match_irq,
    output logic                    overflow_irq,
    output logic                    ser_rx_full_irq,
    output logic                    ser_tx_empty_irq,
    output logic                    ser_tx_done_irq
);
    import tcm_pkg::*;

    tcm_st_s     s;
    tcm_st_s     n;
    logic        lvl;
    logic        tick;
    logic        en;
    logic        compare_reg_match;
    logic        topm;
    logic        mx;
    logic        capl;
    logic        hw_cap;
    logic        cap_ev;
    logic        cap_clr;
    logic        ovf_ev;
    logic        cmp_ev;
    logic        stg;
    logic        wr;
    logic        rd_ok;
    logic [5:0]  fset;
    logic [5:0]  fclr;
    logic [15:0] top;
    logic [7:0]  sh;
    logic [31:0] rdat;
    logic [31:0] wm;

    function automatic logic [31:0] mrg(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // Bus handshakes
    assign s_axi_awready = !s.awv && !s.bv;
    assign s_axi_wready  = !s.wv && !s.bv;
    assign s_axi_bvalid  = s.bv;
    assign s_axi_bresp   = s.br;
    assign s_axi_arready = !s.rv;
    assign s_axi_rvalid  = s.rv;
    assign s_axi_rdata   = s.rd;
    assign s_axi_rresp   = s.rr;

    assign mod_out_pin_1      = s.o1;
    assign mod_out_pin_2      = s.o2;
    assign mod_out_pin_1_oe   = port_ctl.dir1;
    assign mod_out_pin_2_oe   = port_ctl.dir2;
    assign port_pin_serin     = port_ctl.serin;
    assign port_pin_serin_oe  = port_ctl.dirs &&
        (s.modb[3:0] != MD_SSI);
    assign stage_output_clock = s.stg;
    assign capture_irq       = s.flg[F_CAP] & s.msk[F_CAP];
    assign compare_match_irq = s.flg[F_CMP] & s.msk[F_CMP];
    assign overflow_irq      = s.flg[F_OVF] & s.msk[F_OVF];
    assign ser_rx_full_irq   = s.flg[F_RX] & s.msk[F_RX];
    assign ser_tx_empty_irq  = s.flg[F_TX] & s.msk[F_TX];
    assign ser_tx_done_irq   = s.flg[F_TC] & s.msk[F_TC];

    // ==========================================
    // Read mux
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            A_CTLA: rdat = {24'h0, s.ctla};
            A_CTLB: rdat = {24'h0, s.ctlb};
            A_MODA: rdat = {24'h0, s.moda};
            A_MODB: rdat = {24'h0, s.modb};
            A_SDAT: rdat = {24'h0, s.rxb};
            A_FLG:  rdat = {26'h0, s.flg};
            A_MSK:  rdat = {26'h0, s.msk};
            A_CMP:  rdat = {16'h0, s.cmp};
            A_CAP:  rdat = {16'h0, s.cap};
            A_CNT:  rdat = {16'h0, s.cnt};
            default: begin
                rdat  = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        n = s;
        n.sya = {s.sya[0], clk_src.ext_a};
        n.syb = {s.syb[0], clk_src.ext_b};
        n.syc = {s.syc[0], capture_input_pin};
        n.sys = {s.sys[0], serial_in_pin};
        en = s.ctla[CA_EN];
        // Counter clock select
        case (s.moda[2:0])
            3'h0:    lvl = 1'b1;
            3'h1:    lvl = s.sya[1];
            3'h2:    lvl = s.syb[1];
            3'h3:    lvl = clk_src.t0;
            3'h4:    lvl = clk_src.t1;
            3'h5:    lvl = clk_src.t3;
            3'h6:    lvl = clk_src.sens;
            default: lvl = clk_src.base;
        endcase
        n.srcd = lvl;
        tick = (s.moda[2:0] == 3'h0) || (lvl && !s.srcd);
        // Spike filter: level must hold FLT_LEN samples
        if (s.syc[1] == s.flt) begin
            n.fcnt = '0;
        end else if (s.fcnt == FLT_LEN - 3'h1) begin
            n.flt  = s.syc[1];
            n.fcnt = '0;
        end else begin
            n.fcnt = s.fcnt + 3'h1;
        end
        if (!s.ctla[CA_ICS]) begin
            capl = clk_src.t1;
        end else if (s.moda[MA_FLT]) begin
            capl = s.flt;
        end else begin
            capl = s.syc[1];
        end
        n.capd = capl;
        case (s.moda[MA_EDG +: 2])
            2'h0:    hw_cap = capl && !s.capd;
            2'h1:    hw_cap = !capl && s.capd;
            default: hw_cap = capl != s.capd;
        endcase
        hw_cap  = hw_cap && en;
        cap_ev  = hw_cap || s.ctlb[CB_SCE];
        cap_clr = hw_cap && s.modb[MB_CPR];
        // Counter
        case (s.moda[MA_TOP +: 2])
            2'h1:    top = TOP1;
            2'h2:    top = TOP2;
            2'h3:    top = TOP3;
            default: top = MAXC;
        endcase
        compare_reg_match  = s.cnt == s.cmp;
        topm = s.cnt == top;
        mx   = s.cnt == MAXC;
        cmp_ev = en && tick && compare_reg_match;
        ovf_ev = en && tick && (mx || topm) && !(compare_reg_match && s.ctla[CA_CRM]);
        if (s.ctla[CA_CR] || cap_clr) begin
            n.cnt = 16'h0;
        end else if (en && tick) begin
            if (compare_reg_match && s.ctla[CA_CRM]) begin
                n.cnt = 16'h0;
            end else if (mx || topm) begin
                n.cnt = 16'h0;
            end else begin
                n.cnt = s.cnt + 16'h1;
            end
        end
        if (cap_ev) begin
            n.cap = s.cnt;
            n.ctlb[CB_SCE] = 1'b0;
        end
        // Stage output clock from masked events
        stg = (cmp_ev && s.ctla[CA_CTM]) ||
              (ovf_ev && s.ctla[CA_OTM]);
        n.stg = stg;
        if (stg) begin
            n.m2 = !s.m2;
        end
        // Serial unit, shift clock is stage clock halved
        fset = '0;
        fset[F_CAP] = cap_ev;
        fset[F_CMP] = cmp_ev;
        fset[F_OVF] = ovf_ev;
        sh = {s.sr[6:0], s.sys[1]};
        if (!s.modb[MB_SSI]) begin
            n.ss = SS_IDLE;
            n.ph = 1'b0;
        end else if (s.ss == SS_IDLE) begin
            if (s.txf && stg) begin
                n.sr    = s.txb;
                n.so    = s.txb[7];
                n.txf   = 1'b0;
                n.bits  = 3'h0;
                n.ph    = 1'b0;
                n.ss    = SS_SHIFT;
                n.bi    = !s.bi;
                fset[F_TX] = 1'b1;
            end
        end else if (stg) begin
            n.ph = !s.ph;
            if (!s.ph) begin
                if (s.so) begin
                    n.bi = !s.bi;
                end
            end else begin
                n.sr   = sh;
                n.so   = sh[7];
                n.bits = s.bits + 3'h1;
                n.bi   = !s.bi;
                if (s.bits == 3'h7) begin
                    n.rxb = sh;
                    fset[F_RX] = 1'b1;
                    if (s.txf) begin
                        n.sr  = s.txb;
                        n.so  = s.txb[7];
                        n.txf = 1'b0;
                        fset[F_TX] = 1'b1;
                    end else begin
                        n.ss = SS_IDLE;
                        fset[F_TC] = 1'b1;
                    end
                end
            end
        end
        // Modulator pins
        n.o1 = port_ctl.out1;
        n.o2 = port_ctl.out2;
        case (s.modb[3:0])
            MD_TG1: n.o1 = s.m2;
            MD_TG2: n.o2 = s.m2;
            MD_TGB: begin
                n.o1 = s.m2;
                n.o2 = !s.m2;
            end
            MD_SSI: begin
                n.o1 = s.so;
                n.o2 = s.ph ^ s.modb[MB_POL];
            end
            MD_MAN: n.o1 = s.so ^ s.ph;
            MD_BIP: n.o1 = s.bi;
            MD_PWM: n.o1 = s.so & s.m2;
            default: ;
        endcase
        // Bus writes
        if (s_axi_awvalid && s_axi_awready) begin
            n.awv = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.wv = 1'b1;
            n.wd = s_axi_wdata;
            n.ws = s_axi_wstrb;
        end
        wr   = s.awv && s.wv;
        wm   = 32'h0;
        fclr = '0;
        if (wr) begin
            n.awv = 1'b0;
            n.wv  = 1'b0;
            n.bv  = 1'b1;
            n.br  = R_OK;
            case (s.awa)
                A_CTLA: begin
                    wm     = mrg({24'h0, s.ctla}, s.wd, s.ws);
                    n.ctla = wm[7:0] & CTLA_RW;
                    // Toggle on start, once on the enable edge
                    if (wm[CA_EN] && !en && wm[CA_TS]) begin
                        n.m2 = !s.m2;
                    end
                end
                A_CTLB: begin
                    wm = mrg({24'h0, s.ctlb}, s.wd, s.ws);
                    n.ctlb[CB_SCE] = wm[CB_SCE] | n.ctlb[CB_SCE];
                end
                A_MODA: begin
                    wm     = mrg({24'h0, s.moda}, s.wd, s.ws);
                    n.moda = wm[7:0];
                end
                A_MODB: begin
                    wm     = mrg({24'h0, s.modb}, s.wd, s.ws);
                    n.modb = wm[7:0];
                    if (!en) begin
                        n.m2 = wm[MB_PRE];
                    end
                end
                A_SDAT: begin
                    if (s.ws[0]) begin
                        n.txb = s.wd[7:0];
                        n.txf = 1'b1;
                    end
                end
                A_FLG: begin
                    if (s.ws[0]) begin
                        fclr = s.wd[5:0];
                    end
                end
                A_MSK: begin
                    wm    = mrg({26'h0, s.msk}, s.wd, s.ws);
                    n.msk = wm[5:0];
                end
                A_CMP: begin
                    wm    = mrg({16'h0, s.cmp}, s.wd, s.ws);
                    n.cmp = wm[15:0];
                end
                A_CAP, A_CNT: ;
                default: n.br = R_SLV;
            endcase
        end
        n.flg = (s.flg & ~fclr) | fset;
        if (s.bv && s_axi_bready) begin
            n.bv = 1'b0;
        end
        if (s_axi_arvalid && !s.rv) begin
            n.rv = 1'b1;
            n.rd = rdat;
            n.rr = rd_ok ? R_OK : R_SLV;
        end else if (s.rv && s_axi_rready) begin
            n.rv = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cnt_wrap_a: assert property (en && tick && mx && !s.ctla[CA_CR]
        && !cap_clr && !(compare_reg_match && s.ctla[CA_CRM])
        |=> s.cnt == 16'h0 && s.flg[F_OVF])
        else $error("max count did not wrap");
    cnt_step_a: assert property (en && tick && !mx && !topm
        && !compare_reg_match && !s.ctla[CA_CR] && !cap_clr
        |=> s.cnt == $past(s.cnt) + 16'h1)
        else $error("counter did not step");
    cmp_clear_a: assert property (en && tick && compare_reg_match
        && s.ctla[CA_CRM] |=> s.cnt == 16'h0 && s.flg[F_CMP])
        else $error("match did not clear counter");
    top_hit_a: assert property (en && tick && s.moda[4:3] == 2'h1
        && s.cnt == TOP1 && !compare_reg_match |=> s.cnt == 16'h0)
        else $error("fixed top ignored");
    cap_copy_a: assert property (cap_ev
        |=> s.cap == $past(s.cnt) && s.flg[F_CAP])
        else $error("capture lost count");
    soft_done_a: assert property (s.ctlb[CB_SCE] && !wr
        |=> !s.ctlb[CB_SCE])
        else $error("soft capture stuck");
    m2_flip_a: assert property (stg
        && !(wr && s.awa == A_MODB)
        |=> s.m2 != $past(s.m2) && stage_output_clock)
        else $error("toggle missed");
    sclk_half_a: assert property (s.ss == SS_SHIFT && stg
        && s.modb[MB_SSI] |=> s.ph != $past(s.ph))
        else $error("shift clock not halved");
    serin_in_a: assert property (s.modb[3:0] == MD_SSI
        |-> !port_pin_serin_oe)
        else $error("serial pin driven");
    pin_tg_a: assert property (s.modb[3:0] == MD_TG1
        |=> mod_out_pin_1 == $past(s.m2))
        else $error("toggle not on pin 1");
    irq_gate_a: assert property (wr && s.awa == A_FLG && s.ws[0]
        && s.wd[F_OVF] && !ovf_ev |=> !overflow_irq)
        else $error("overflow flag not cleared");
endmodule // tcm_timer

/* tb/tcm_ser_peer.sv */
// Serial peripheral model on the modulator data and shift clock pins
`timescale 1ns/100ps
module tcm_ser_peer (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       sclk,
    input  wire logic       sdo,
    output logic            sdi,
    output logic [7:0]      rx_byte,
    output logic [3:0]      rx_bits
);
    logic       sclk_d;
    logic [7:0] tx_sh;
    // Reply data moves on the falling shift clock, holds between falling edges
    assign sdi = tx_sh[7];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d  <= 1'b0;
            tx_sh   <= 8'h5a;
            rx_byte <= 8'h00;
            rx_bits <= 4'h0;
        end else begin
            sclk_d <= sclk;
            if (sclk && !sclk_d) begin
                rx_byte <= {rx_byte[6:0], sdo};
                rx_bits <= rx_bits + 4'h1;
            end
            if (!sclk && sclk_d) begin
                tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
            end
        end
    end
endmodule // tcm_ser_peer

/* tb/tcm_timer_tb_top.sv */
// Self-checking testbench of the capture/compare timer
`timescale 1ns/100ps
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module tcm_timer_tb_top;
    import tcm_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, peer_bits, b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    tcm_src_s    clk_src;
    tcm_port_s   port_ctl;
    logic        capture_input_pin, serial_in_pin, mod_out_pin_1;
    logic        mod_out_pin_2, mod_out_pin_1_oe, mod_out_pin_2_oe;
    logic        port_pin_serin, port_pin_serin_oe, stage_output_clock;
    logic        capture_irq, compare_match_irq, overflow_irq, bit1;
    logic        ser_rx_full_irq, ser_tx_empty_irq, ser_tx_done_irq;
    logic [7:0]  peer_byte;
    int          num_errors, checked, cyc, p;

    tcm_timer dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .clk_src, .capture_input_pin,
        .port_ctl, .serial_in_pin, .mod_out_pin_1, .mod_out_pin_1_oe,
        .mod_out_pin_2, .mod_out_pin_2_oe, .port_pin_serin,
        .port_pin_serin_oe, .stage_output_clock, .capture_irq,
        .compare_match_irq, .overflow_irq, .ser_rx_full_irq,
        .ser_tx_empty_irq, .ser_tx_done_irq
    );
    tcm_ser_peer peer_u (
        .aclk(aclk), .aresetn(aresetn), .sclk(mod_out_pin_2),
        .sdo(mod_out_pin_1), .sdi(serial_in_pin), .rx_byte(peer_byte),
        .rx_bits(peer_bits)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ==========================================
    // Closing report and hang guard
    task automatic results();
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            results();
        end
    end
    // ==========================================
    // Bus cycles; values seen right after an edge are the sampled ones
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic period();
        p = 0;
        do @(posedge aclk); while (stage_output_clock !== 1'b1);
        do begin
            @(posedge aclk);
            p++;
        end while (stage_output_clock !== 1'b1);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd_reg(A_CNT);
        `CHK(rd, 32'h0)
        rd_reg(6'h3c);
        `CHK(rr, R_SLV)
        wr(A_CTLA, 32'h7f);
        rd_reg(A_CTLA);
        `CHK(rd, 32'h6f)
        wr(A_CTLA, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wr(A_MODB, 32'(m));
            rd_reg(A_MODB);
            `CHK(rd, 32'(m))
        end
        wr(A_MODB, 32'h0);
        rd_reg(A_MODB);
        `CHK(mod_out_pin_1, 1'b1)
        `CHK(mod_out_pin_1_oe, 1'b1)
    endtask
    task automatic t_cap();
        wr(A_CTLA, 32'h80);
        wr(A_CTLA, 32'h0);
        rd_reg(A_CNT);
        b0 = 4'h0;
        p = int'(rd);
        wr(A_CTLB, 32'h1);
        rd_reg(A_CAP);
        `CHK(rd, 32'(p))
        rd_reg(A_CTLB);
        `CHK(rd, 32'h0)
        wr(A_MSK, 32'h1);
        wr(A_FLG, 32'h3f);
        wr(A_MODA, 32'h80);
        wr(A_CTLA, 32'ha0);
        capture_input_pin <= 1'b1;
        repeat (2) @(posedge aclk);
        capture_input_pin <= 1'b0;
        repeat (16) @(posedge aclk);
        `CHK(capture_irq, 1'b0)
        capture_input_pin <= 1'b1;
        repeat (16) @(posedge aclk);
        `CHK(capture_irq, 1'b1)
        wr(A_CTLA, 32'h4);
        wr(A_MSK, 32'h0);
    endtask
    task automatic t_cmp();
        wr(A_CMP, 32'h4);
        wr(A_MODB, 32'(MD_TGB));
        wr(A_CTLA, 32'hca);
        @(posedge aclk);
        `CHK(mod_out_pin_1, 1'b1)
        period();
        `CHK(p, 5)
        `CHK(compare_match_irq, 1'b0)
        `CHK(mod_out_pin_2, ~mod_out_pin_1)
        bit1 = mod_out_pin_1;
        repeat (5) @(posedge aclk);
        `CHK(mod_out_pin_1, ~bit1)
        port_ctl.dir2 <= 1'b0;
        wr(A_MSK, 32'h2);
        `CHK(compare_match_irq, 1'b1)
        `CHK(mod_out_pin_2_oe, 1'b0)
        port_ctl.dir2 <= 1'b1;
        wr(A_CTLA, 32'h4);
        wr(A_MSK, 32'h0);
    endtask
    task automatic t_top();
        for (int t = 1; t < 4; t++) begin
            wr(A_MODA, 32'(t << 3));
            wr(A_CTLA, 32'h81);
            period();
            `CHK(p, 256 << (t - 1))
            wr(A_CTLA, 32'h4);
        end
        rd_reg(A_FLG);
        `CHK(rd[F_OVF], 1'b1)
        wr(A_MSK, 32'h4);
        `CHK(overflow_irq, 1'b1)
        wr(A_FLG, 32'h4);
        rd_reg(A_FLG);
        `CHK(rd[F_OVF], 1'b0)
        `CHK(overflow_irq, 1'b0)
        wr(A_MSK, 32'h0);
    endtask
    task automatic t_ser();
        wr(A_CMP, 32'h3);
        wr(A_FLG, 32'h3f);
        wr(A_MODB, 32'h14);
        b0 = peer_bits;
        wr(A_SDAT, 32'hc3);
        wr(A_CTLA, 32'h8a);
        `CHK(port_pin_serin_oe, 1'b0)
        p = 0;
        do begin
            rd_reg(A_FLG);
            p++;
        end while (rd[F_TC] !== 1'b1 && p < 300);
        `CHK(rd[F_RX], 1'b1)
        `CHK(peer_byte, 8'hc3)
        `CHK(4'(peer_bits - b0), 4'h8)
        wr(A_MSK, 32'h38);
        `CHK(ser_rx_full_irq, 1'b1)
        `CHK(ser_tx_empty_irq, 1'b1)
        `CHK(ser_tx_done_irq, 1'b1)
        `CHK(port_pin_serin, 1'b0)
        wr(A_MSK, 32'h0);
        wr(A_CTLA, 32'h0);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, capture_input_pin} = 3'h0;
        s_axi_awaddr = 6'h00;
        s_axi_araddr = 6'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        clk_src = 7'h00;
        port_ctl = 6'h27;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_cap();
        t_cmp();
        t_top();
        t_ser();
        results();
    end
endmodule // tcm_timer_tb_top
